// File: gtc_defines.svh
// Register map, field positions and reset values for the gated timer.
// Assumes a 32-bit AXI4-Lite register bus.
`ifndef GTC_DEFINES_SVH
`define GTC_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define GTC_CTRL_OFF     4'h0
`define GTC_GATE_OFF     4'h4
`define GTC_CNT_LO_OFF   4'h8
`define GTC_CNT_HI_OFF   4'hC
`define GTC_STAT_OFF     5'h10

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define GTC_ON_BIT       0
`define GTC_SYNCD_BIT    2
`define GTC_OSCEN_BIT    3
`define GTC_PS_LSB       4
`define GTC_SRC_LSB      6

// ----------------------------------------------------------------
// Gate register fields, status fields
// ----------------------------------------------------------------
`define GTC_GPOL_BIT     6
`define GTC_GEN_BIT      7
`define GTC_OVF_BIT      0

`define GTC_CTRL_RST     8'h00
`define GTC_GATE_RST     8'h00
`define GTC_CNT_RST      16'h0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define GTC_CLK_MHZ      200
`define GTC_INSTR_DIV    4

`endif

// File: gtc_pkg.sv
// Types shared by the gated timer design.
// Assumes nothing beyond the defines header.
package gtc_pkg;
    typedef enum logic [1:0] {
        GTC_SRC_INSTR,
        GTC_SRC_SYS,
        GTC_SRC_EXT,
        GTC_SRC_RSVD
    } gtc_src_e;
    typedef enum logic [1:0] {
        GTC_RSP_OKAY   = 2'h0,
        GTC_RSP_SLVERR = 2'h2
    } gtc_resp_e;
endpackage : gtc_pkg

// File: gtc_timer.sv
// Gated 16-bit timer/counter with 3-bit prescaler and AXI4-Lite registers.
// Assumes ext_count_pin and crystal_in_pin are synchronous to ref_clk samples.
//
// Overview of operation
// - Counter off when counter_on clear; gate_enable selects free or gated counting.
// - 16-bit up counter read as two bytes; byte write loads it immediately.
// - Source select plus crystal enable chooses instruction, system, pin or crystal.
// - Instruction clock source advances counter once per instruction cycle.
// - System clock source advances four counts per instruction cycle.
// - External source counts rising edges, synchronised or asynchronous.
// - External mode needs a falling edge before first counted rising edge.
// - Prescale select divides count clock by 1, 2, 4 or 8.
// - Prescaler hidden from software; cleared on any counter byte write.
// - Crystal enable starts low-power oscillator, which keeps running in sleep.
// - Sync-disable set counts external input without synchronising it.
// - Asynchronous external counting continues in sleep; overflow wakes processor.
// - Sync mode changes may lose or add one count.
// - Byte reads during asynchronous counting always return a valid value.
// - Gated counting only when gate_pin level equals gate_polarity.
// - Counter holds its value while the gate forbids counting.
// - Rollover from all ones to zero sets sticky overflow_flag until cleared.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "gtc_defines.svh"

module gtc_timer
    import gtc_pkg::*;
#(
    parameter int CNT_W = 16,                       // Counter width
    parameter int PS_W  = 3                         // Prescaler width
) (
    input  wire logic        ref_clk,               // System clock, 200 MHz
    input  wire logic        rst,                   // Sync reset, active high
    input  wire logic        clk_en,                // Freezes all state when low
    input  wire logic        sleep_mode,            // Processor asleep
    input  wire logic        ext_count_pin,         // External count input
    input  wire logic        crystal_in_pin,        // Crystal oscillator signal
    input  wire logic        gate_pin,              // Gate input
    output logic             crystal_osc_run,       // Crystal oscillator enable
    output logic             overflow_flag,         // Sticky rollover flag
    output logic             wake_req,              // Wake request in sleep
    input  wire logic [4:0]  s_axi_awaddr,          // Write address
    input  wire logic        s_axi_awvalid,         // Write address valid
    output logic             s_axi_awready,         // Write address ready
    input  wire logic [31:0] s_axi_wdata,           // Write data
    input  wire logic [3:0]  s_axi_wstrb,           // Write strobes
    input  wire logic        s_axi_wvalid,          // Write data valid
    output logic             s_axi_wready,          // Write data ready
    output logic [1:0]       s_axi_bresp,           // Write response
    output logic             s_axi_bvalid,          // Write response valid
    input  wire logic        s_axi_bready,          // Write response ready
    input  wire logic [4:0]  s_axi_araddr,          // Read address
    input  wire logic        s_axi_arvalid,         // Read address valid
    output logic             s_axi_arready,         // Read address ready
    output logic [31:0]      s_axi_rdata,           // Read data
    output logic [1:0]       s_axi_rresp,           // Read response
    output logic             s_axi_rvalid,          // Read data valid
    input  wire logic        s_axi_rready           // Read data ready
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0]       ctrl_r;
    logic [7:0]       gate_r;
    logic [CNT_W-1:0] count_r;
    logic [PS_W-1:0]  ps_r;
    logic [1:0]       instr_r;
    logic             sync1_r;
    logic             sync2_r;
    logic             ext_prev_r;
    logic             armed_r;
    logic             aw_got_r;
    logic             w_got_r;
    logic [4:0]       aw_r;
    logic [31:0]      wd_r;
    logic [3:0]       ws_r;

    logic             counter_on;
    logic             gate_enable;
    logic             gate_polarity;
    logic             crystal_osc_enable;
    logic             sync_disable;
    logic [1:0]       prescale_select;
    gtc_src_e         count_source_select;

    assign counter_on          = ctrl_r[`GTC_ON_BIT];
    assign sync_disable        = ctrl_r[`GTC_SYNCD_BIT];
    assign crystal_osc_enable  = ctrl_r[`GTC_OSCEN_BIT];
    assign prescale_select     = ctrl_r[`GTC_PS_LSB +: 2];
    assign count_source_select = gtc_src_e'(ctrl_r[`GTC_SRC_LSB +: 2]);
    assign gate_enable         = gate_r[`GTC_GEN_BIT];
    assign gate_polarity       = gate_r[`GTC_GPOL_BIT];

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    logic wr_fire;
    logic cnt_lo_wr;
    logic cnt_hi_wr;
    logic cnt_wr;
    logic wr_hit;

    assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
    assign wr_fire       = aw_got_r && w_got_r && !s_axi_bvalid;
    assign wr_hit        = wr_fire && ws_r[0];
    assign cnt_lo_wr     = wr_hit && (aw_r[4:2] == 3'(`GTC_CNT_LO_OFF >> 2));
    assign cnt_hi_wr     = wr_hit && (aw_r[4:2] == 3'(`GTC_CNT_HI_OFF >> 2));
    assign cnt_wr        = cnt_lo_wr || cnt_hi_wr;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            aw_r         <= 5'h00;
            wd_r         <= 32'h0000_0000;
            ws_r         <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= GTC_RSP_OKAY;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                aw_r     <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wd_r    <= s_axi_wdata;
                ws_r    <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_r > `GTC_STAT_OFF) ? GTC_RSP_SLVERR : GTC_RSP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_r <= `GTC_CTRL_RST;
            gate_r <= `GTC_GATE_RST;
        end else if (clk_en && wr_hit) begin
            if (aw_r[4:2] == 3'(`GTC_CTRL_OFF >> 2)) begin
                ctrl_r <= wd_r[7:0] & 8'hFD;
            end
            if (aw_r[4:2] == 3'(`GTC_GATE_OFF >> 2)) begin
                gate_r <= wd_r[7:0] & 8'hC0;
            end
        end
    end

    // ------------------------------------------------------------
    // Count clock selection and synchronisation
    // ------------------------------------------------------------
    logic ext_raw;
    logic ext_lvl;
    logic tick;
    logic gate_ok;
    logic run;
    logic ps_out;
    logic [3:0] ps_max;

    assign crystal_osc_run = crystal_osc_enable;
    assign ext_raw = crystal_osc_enable ? crystal_in_pin : ext_count_pin;
    assign ext_lvl = sync_disable ? ext_raw : sync2_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else if (clk_en) begin
            sync1_r <= ext_raw;
            sync2_r <= sync1_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            instr_r <= 2'h0;
        end else if (clk_en) begin
            instr_r <= instr_r + 2'h1;
        end
    end

    // Falling edge must be seen before first counted rising edge
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ext_prev_r <= 1'b0;
            armed_r    <= 1'b0;
        end else if (clk_en) begin
            ext_prev_r <= ext_lvl;
            if (cnt_wr || !counter_on) begin
                armed_r <= 1'b0;
            end else if (ext_prev_r && !ext_lvl) begin
                armed_r <= 1'b1;
            end
        end
    end

    always_comb begin
        unique case (count_source_select)
            GTC_SRC_INSTR: tick = (instr_r == 2'h3);
            GTC_SRC_SYS:   tick = 1'b1;
            GTC_SRC_EXT:   tick = armed_r && ext_lvl && !ext_prev_r;
            GTC_SRC_RSVD:  tick = 1'b0;
        endcase
    end

    // Sleep only stops synchronous or internal sources
    assign gate_ok = !gate_enable || (gate_pin == gate_polarity);
    assign run     = counter_on && gate_ok && tick
                     && (!sleep_mode || (sync_disable
                         && count_source_select == GTC_SRC_EXT));

    // ------------------------------------------------------------
    // Prescaler and counter
    // ------------------------------------------------------------
    assign ps_max = (4'h1 << prescale_select) - 4'h1;
    assign ps_out = run && ({1'b0, ps_r} == ps_max);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ps_r <= '0;
        end else if (clk_en) begin
            if (cnt_wr) begin
                ps_r <= '0;
            end else if (ps_out) begin
                ps_r <= '0;
            end else if (run) begin
                ps_r <= ps_r + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count_r <= `GTC_CNT_RST;
        end else if (clk_en) begin
            if (cnt_lo_wr) begin
                count_r[7:0] <= wd_r[7:0];
            end else if (cnt_hi_wr) begin
                count_r[15:8] <= wd_r[7:0];
            end else if (ps_out) begin
                count_r <= count_r + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Overflow flag, wake request
    // ------------------------------------------------------------
    logic ovf_evt;
    logic ovf_clr;

    assign ovf_evt = ps_out && (count_r == '1) && !cnt_wr;
    assign ovf_clr = wr_hit && (aw_r == `GTC_STAT_OFF) && wd_r[`GTC_OVF_BIT];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            overflow_flag <= 1'b0;
        end else if (clk_en) begin
            if (ovf_evt) begin
                overflow_flag <= 1'b1;
            end else if (ovf_clr) begin
                overflow_flag <= 1'b0;
            end
        end
    end

    assign wake_req = overflow_flag && sleep_mode;

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    logic [31:0] rd_val;

    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (s_axi_araddr)
            5'(`GTC_CTRL_OFF):   rd_val[7:0] = ctrl_r;
            5'(`GTC_GATE_OFF):   rd_val[7:0] = gate_r;
            5'(`GTC_CNT_LO_OFF): rd_val[7:0] = count_r[7:0];
            5'(`GTC_CNT_HI_OFF): rd_val[7:0] = count_r[15:8];
            `GTC_STAT_OFF:   rd_val[0]   = overflow_flag;
            default:         rd_val      = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= GTC_RSP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_val;
                s_axi_rresp  <= (s_axi_araddr[1:0] != 2'h0 || s_axi_araddr > `GTC_STAT_OFF)
                                ? GTC_RSP_SLVERR : GTC_RSP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_off_holds: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && !counter_on && !cnt_wr |=> $stable(count_r))
        else $error("counter moved while off");

    a_gate_hold: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && gate_enable && gate_pin != gate_polarity && !cnt_wr |=> $stable(count_r))
        else $error("counter moved while gated");

    a_lo_load: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && cnt_lo_wr |=> count_r[7:0] == $past(wd_r[7:0]))
        else $error("low byte not loaded");

    a_ps_clear: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && cnt_wr |=> ps_r == '0)
        else $error("prescaler not cleared");

    a_sys_four: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && counter_on && !gate_enable && !sleep_mode && prescale_select == 2'h0
         && count_source_select == GTC_SRC_SYS && !cnt_wr) [*4]
        |=> count_r == $past(count_r, 4) + 16'h4)
        else $error("system clock rate wrong");

    a_instr_once: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && count_source_select == GTC_SRC_INSTR && instr_r != 2'h3 && !cnt_wr
        |=> $stable(count_r))
        else $error("instruction clock counted early");

    a_ovf_sets: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && ovf_evt |=> overflow_flag && count_r == '0)
        else $error("overflow not flagged");

    a_arm_first: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && (cnt_wr || !counter_on || (!armed_r && !(ext_prev_r && !ext_lvl)))
        |=> !armed_r)
        else $error("armed without falling edge");

    a_div_eight: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && prescale_select == 2'h3 && run && ps_r != 3'h7 && !cnt_wr |=> $stable(count_r))
        else $error("divide by eight wrong");

endmodule : gtc_timer

// File: gtc_far_end.sv
// Far-side model: external count pin, crystal signal and gate input.
// Assumes the bench calls its tasks right after a rising edge of ref_clk.
`timescale 1ns/1ps

module gtc_far_end (
    input  wire logic ref_clk,        // Bench clock
    output logic      ext_count_pin,  // External count level
    output logic      crystal_in_pin, // Crystal signal level
    output logic      gate_pin        // Gate level
);
    // ------------------------------------------------------------
    // Lines stand still low until a scenario drives them
    // ------------------------------------------------------------
    initial begin
        ext_count_pin  = 1'b0;
        crystal_in_pin = 1'b0;
        gate_pin       = 1'b0;
    end

    // Line 0 count pin, 1 crystal, 2 gate
    task automatic drive(input int sel, input logic v);
        @(posedge ref_clk);
        if (sel == 0) ext_count_pin <= v;
        else if (sel == 1) crystal_in_pin <= v;
        else gate_pin <= v;
    endtask : drive

    // Slow whole pulses, each rise followed by its own fall four cycles later
    task automatic pulses(input int sel, input int k);
        repeat (k) begin
            drive(sel, 1'b1);
            repeat (3) @(posedge ref_clk);
            drive(sel, 1'b0);
            repeat (3) @(posedge ref_clk);
        end
    endtask : pulses

    task automatic gate_for(input logic lvl, input int n);
        drive(2, lvl);
        repeat (n) @(posedge ref_clk);
        gate_pin <= ~lvl;
    endtask : gate_for
endmodule : gtc_far_end

// File: tb_top.sv
// Self-checking bench for the gated timer, driving its AXI4-Lite registers.
// Assumes gtc_far_end supplies the count, crystal and gate lines.
`timescale 1ns/1ps
`include "gtc_defines.svh"

module tb_top;
    import gtc_pkg::*;
    localparam logic [4:0] A_CTRL = {1'b0, `GTC_CTRL_OFF};
    localparam logic [4:0] A_GATE = {1'b0, `GTC_GATE_OFF};
    localparam logic [4:0] A_LO   = {1'b0, `GTC_CNT_LO_OFF};
    localparam logic [4:0] A_HI   = {1'b0, `GTC_CNT_HI_OFF};
    localparam logic [4:0] A_STAT = `GTC_STAT_OFF;
    localparam int         WATCH  = 400000;  // Some forty times the expected run
    logic        ref_clk = 1'b0, rst = 1'b1, sleep_mode = 1'b0;
    logic        ext_count_pin, crystal_in_pin, gate_pin;
    logic        crystal_osc_run, overflow_flag, wake_req;
    logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 32'h0, rdata, rdat;
    logic [1:0]  bresp, rresp, last_rsp;
    logic [15:0] cnt;
    logic [31:0] seed = 32'h4B92;
    logic [4:0]  regs[5] = '{A_CTRL, A_GATE, A_LO, A_HI, A_STAT};
    int          failures = 0, checks = 0;

    always #2.5 ref_clk = ~ref_clk;

    gtc_timer i_dut (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1), .sleep_mode(sleep_mode),
        .ext_count_pin(ext_count_pin), .crystal_in_pin(crystal_in_pin), .gate_pin(gate_pin),
        .crystal_osc_run(crystal_osc_run), .overflow_flag(overflow_flag), .wake_req(wake_req),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    gtc_far_end i_far (.ref_clk(ref_clk), .ext_count_pin(ext_count_pin),
        .crystal_in_pin(crystal_in_pin), .gate_pin(gate_pin));

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic near(input logic [15:0] s, input int e, input int t);
        return !$isunknown(s) && (int'(s) >= e - t) && (int'(s) <= e + t);
    endfunction : near
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [31:0] ctl(input logic [1:0] src, input logic [1:0] ps,
                                        input logic osc, input logic sd, input logic on);
        return {24'h0, src, ps, osc, sd, 1'b0, on};
    endfunction : ctl
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic ta, tw, da, dw;
        da = 1'b0;
        dw = 1'b0;
        @(posedge ref_clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(negedge ref_clk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            @(posedge ref_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            da = da | ta;
            dw = dw | tw;
        end while (!(da && dw));
        do @(negedge ref_clk); while (!bvalid);
        last_rsp = bresp;
        @(posedge ref_clk);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a);
        @(posedge ref_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(negedge ref_clk); while (!arready);
        @(posedge ref_clk);
        arvalid <= 1'b0;
        do @(negedge ref_clk); while (!rvalid);
        rdat = rdata;
        last_rsp = rresp;
        @(posedge ref_clk);
        rready <= 1'b0;
    endtask : rd
    task automatic set_cnt(input logic [15:0] v);
        wr(A_LO, {24'h0, v[7:0]});
        wr(A_HI, {24'h0, v[15:8]});
    endtask : set_cnt
    task automatic rd_cnt();
        rd(A_LO);
        cnt[7:0] = rdat[7:0];
        rd(A_HI);
        cnt[15:8] = rdat[7:0];
    endtask : rd_cnt
    // Stopped load, optional fall after start, k pulses, stop and read
    task automatic ext_run(input logic [31:0] c, input int sel, input logic fall,
                           input int k, input logic [15:0] start);
        wr(A_CTRL, {c[31:1], 1'b0});
        set_cnt(start);
        i_far.drive(sel, fall);
        repeat (8) @(posedge ref_clk);
        wr(A_CTRL, c);
        i_far.drive(sel, 1'b0);
        i_far.pulses(sel, k);
        repeat (6) @(posedge ref_clk);
        wr(A_CTRL, {c[31:1], 1'b0});
        rd_cnt();
    endtask : ext_run
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    initial begin
        #(WATCH);
        failures++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (regs[i]) begin
            rd(regs[i]);
            check(rdat, 32'h0);
        end
        rd(5'h14);
        check(rdat, 32'h0);
        check(32'(last_rsp), 32'(GTC_RSP_SLVERR));
        wr(5'h14, 32'hFF);
        check(32'(last_rsp), 32'(GTC_RSP_SLVERR));
        repeat (4) begin
            seed = lfsr(seed);
            set_cnt(seed[15:0]);
            rd_cnt();
            check(32'(cnt), 32'(seed[15:0]));
        end
        $display("test bus and load done");
        for (int sd = 0; sd < 2; sd++) begin
            for (int ps = 0; ps < 4; ps++) begin
                ext_run(ctl(2'h2, 2'(ps), 1'b0, 1'(sd), 1'b1), 0, 1'b1, 8, 16'h0000);
                check(32'(cnt), 32'(8 >> ps));
            end
        end
        ext_run(ctl(2'h2, 2'h0, 1'b0, 1'b0, 1'b1), 0, 1'b0, 5, 16'h0000);
        check(32'(cnt), 32'h4);
        ext_run(ctl(2'h2, 2'h0, 1'b1, 1'b0, 1'b1), 1, 1'b1, 5, 16'h0000);
        check(32'(cnt), 32'h5);
        check(32'(crystal_osc_run), 32'h1);
        ext_run(ctl(2'h2, 2'h0, 1'b1, 1'b0, 1'b1), 0, 1'b1, 5, 16'h0000);
        check(32'(cnt), 32'h0);
        ext_run(ctl(2'h2, 2'h1, 1'b0, 1'b0, 1'b1), 0, 1'b1, 1, 16'h0000);
        ext_run(ctl(2'h2, 2'h1, 1'b0, 1'b0, 1'b1), 0, 1'b1, 3, 16'h0000);
        check(32'(cnt), 32'h1);
        $display("test external counting done");
        for (int pol = 0; pol < 2; pol++) begin
            for (int src = 0; src < 2; src++) begin
                wr(A_CTRL, 32'h0);
                set_cnt(16'h0000);
                i_far.drive(2, 1'(1 - pol));
                wr(A_GATE, {24'h0, 1'b1, 1'(pol), 6'h0});
                wr(A_CTRL, ctl(2'(src), 2'h0, 1'b0, 1'b0, 1'b1));
                repeat (20) @(posedge ref_clk);
                rd_cnt();
                check(32'(cnt), 32'h0);
                i_far.gate_for(1'(pol), 80);
                repeat (6) @(posedge ref_clk);
                rd_cnt();
                check({31'h0, near(cnt, src ? 80 : 20, 2)}, 32'h1);
            end
        end
        wr(A_GATE, 32'h0);
        $display("test gating done");
        wr(A_CTRL, 32'h0);
        set_cnt(16'hFFFE);
        wr(A_CTRL, ctl(2'h1, 2'h0, 1'b0, 1'b0, 1'b0));
        repeat (20) @(posedge ref_clk);
        rd_cnt();
        check(32'(cnt), 32'hFFFE);
        wr(A_CTRL, ctl(2'h3, 2'h0, 1'b0, 1'b0, 1'b1));
        repeat (20) @(posedge ref_clk);
        rd_cnt();
        check(32'(cnt), 32'hFFFE);
        wr(A_CTRL, ctl(2'h1, 2'h0, 1'b0, 1'b0, 1'b1));
        wr(A_CTRL, 32'h0);
        repeat (20) @(negedge ref_clk);
        check(32'(overflow_flag), 32'h1);
        check(32'(wake_req), 32'h0);
        rd(A_STAT);
        check(rdat, 32'h1);
        wr(A_STAT, 32'h1);
        @(negedge ref_clk);
        check(32'(overflow_flag), 32'h0);
        @(posedge ref_clk);
        sleep_mode <= 1'b1;
        ext_run(ctl(2'h2, 2'h0, 1'b0, 1'b1, 1'b1), 0, 1'b1, 1, 16'hFFFF);
        check(32'(cnt), 32'h0);
        @(negedge ref_clk);
        check(32'(wake_req), 32'h1);
        wr(A_CTRL, ctl(2'h1, 2'h0, 1'b0, 1'b0, 1'b1));
        repeat (20) @(posedge ref_clk);
        wr(A_CTRL, 32'h0);
        rd_cnt();
        check(32'(cnt), 32'h0);
        $display("test overflow and sleep done");
        wrap_up();
    end
endmodule : tb_top
